// ### hw/phy_mgmt_status_regs.sv
// The APB interface to the registers was chosen for this implementation.
`include "phy_mgmt_regs.svh"

module phy_mgmt_status_regs #(
	parameter int          MGMT_CYCLES    = `MGMT_CYCLES, // cycles per transceiver access
	parameter logic [4:0]  SILICON_REV    = 5'h06,        // arbitrary value
	parameter logic [21:0] VENDOR_BITS    = 22'h000155,   // arbitrary value
	parameter logic [5:0]  PART_FIELD     = 6'h11,        // arbitrary value
	parameter logic [3:0]  REV_FIELD      = 4'h2          // arbitrary value
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	output logic      [15:0] led_config,
	input  wire logic        link_up_pin,
	input  wire logic        jabber_pin,
	input  wire logic        tx_active_pin,
	input  wire logic        rx_active_pin,
	input  wire logic        collision_pin,
	input  wire logic        full_duplex_pin,
	input  wire logic        polarity_rev_pin
);

	// register map, one 32-bit word per register, byte address is four times the index:
	//   0 command, 1 status, 2 register select, 3 write data,
	//   4 read result, 5 silicon revision, 6 event status, 7 event mask
	// every access takes exactly one wait state; read data is registered in
	// the first access cycle so prdata never comes straight from the mux

	// down-counter sized so that MGMT_CYCLES - 1 always fits
	localparam int CNT_W = $clog2(MGMT_CYCLES + 1);

	// synchronised transceiver status levels
	logic [6:0]  pins_s;

	// software-visible registers
	logic        single_read_request_q;  // one-shot read request
	logic        continuous_poll_enable_q; // scan enable
	logic [4:0]  phy_reg_select_q;       // transceiver register address
	logic [15:0] phy_write_data_q;       // data for a pending write
	logic        write_req_q;            // write waiting for the engine
	logic [15:0] phy_read_result_q;      // last read result
	logic        read_result_pending_q;  // result not valid yet
	logic [`IRQ_WIDTH-1:0] irq_stat_q;   // sticky events
	logic [`IRQ_WIDTH-1:0] irq_mask_q;   // enables onto irq

	// engine
	phy_mgmt_pkg::eng_state_t state_q;
	phy_mgmt_pkg::eng_op_t    op_q;
	logic [CNT_W-1:0]         cnt_q;     // cycles left in an access
	logic [4:0]               acc_addr_q; // address latched at start
	logic                     bank_rd;
	logic                     bank_wr;
	logic [15:0]              bank_rdata;
	logic                     rd_done;   // read result captured this cycle
	logic                     wr_done;   // write finished this cycle
	logic                     start_wr;
	logic                     start_rd;

	// apb decode
	logic        ack_q;                  // access phase has waited one cycle
	logic        hit;
	logic [3:0]  idx;
	logic        wr_fire;
	logic        rd_fire;
	logic [31:0] rd_mux;
	logic [`STAT_WIDTH-1:0] mgmt_status_reg;
	logic [`CMD_WIDTH-1:0]  mgmt_command_reg;

	// status pins cross in through two flops
	// the levels are slow and unrelated to each other, so a plain per-bit chain is enough
	pin_sync #(
		.WIDTH (7)
	) u_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.async_in ({link_up_pin, jabber_pin, tx_active_pin, rx_active_pin,
		            collision_pin, full_duplex_pin, polarity_rev_pin}),
		.sync_out (pins_s)
	);

	// transceiver register file behind the management link
	phy_reg_bank #(
		.VENDOR_BITS (VENDOR_BITS),
		.PART_FIELD  (PART_FIELD),
		.REV_FIELD   (REV_FIELD)
	) u_bank (
		.sys_clk    (sys_clk),
		.rst        (rst),
		.rd_en      (bank_rd),
		.wr_en      (bank_wr),
		.addr       (acc_addr_q),
		.wdata      (phy_write_data_q),
		.rdata      (bank_rdata),
		.led_config (led_config),
		.link_up    (pins_s[6]),
		.jabber     (pins_s[5]),
		.tx_act     (pins_s[4]),
		.rx_act     (pins_s[3]),
		.col_act    (pins_s[2]),
		.full_dpx   (pins_s[1]),
		.pol_rev    (pins_s[0])
	);

	// word index, only aligned words inside the map hit
	assign idx     = paddr[5:2];
	assign hit     = (paddr[31:6] == '0) && (paddr[1:0] == 2'h0) && (idx <= `IDX_LAST);
	assign wr_fire = psel && penable && ack_q && pwrite && hit;
	assign rd_fire = psel && penable && !ack_q;

	// one wait state so read data comes from a flop
	always_ff @(posedge sys_clk) begin
		if (rst)
			ack_q <= 1'b0;
		else
			ack_q <= psel && penable && !ack_q;
	end

	assign pready  = ack_q;
	assign pslverr = ack_q && !hit;

	// engine start conditions; a write outranks a read, a single read and the scan launch the same read
	assign start_wr = (state_q == phy_mgmt_pkg::ENG_IDLE) && write_req_q;
	assign start_rd = (state_q == phy_mgmt_pkg::ENG_IDLE) && !write_req_q &&
	                  (single_read_request_q || continuous_poll_enable_q);

	// bank strobes on the last counted cycle
	assign bank_rd = (state_q == phy_mgmt_pkg::ENG_RUN) && (cnt_q == '0) && (op_q == phy_mgmt_pkg::OP_READ);
	assign bank_wr = (state_q == phy_mgmt_pkg::ENG_RUN) && (cnt_q == '0) && (op_q == phy_mgmt_pkg::OP_WRITE);
	assign rd_done = (state_q == phy_mgmt_pkg::ENG_FIN) && (op_q == phy_mgmt_pkg::OP_READ);
	assign wr_done = (state_q == phy_mgmt_pkg::ENG_FIN) && (op_q == phy_mgmt_pkg::OP_WRITE);

	// engine sequencing, start edge E:
	//   E                  leaves idle, address frozen, pending set
	//   E+MGMT_CYCLES      bank strobe edge, transceiver word registered
	//   E+MGMT_CYCLES+1    result, pending clear and event bit land
	// the extra finish cycle costs one cycle per scan pass but keeps the bank
	// read data and the result capture in separate flops
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q    <= phy_mgmt_pkg::ENG_IDLE;
			op_q       <= phy_mgmt_pkg::OP_READ;
			cnt_q      <= '0;
			acc_addr_q <= '0;
		end else begin
			case (state_q)
				phy_mgmt_pkg::ENG_IDLE: begin
					// address is frozen for the whole access
					if (start_wr || start_rd) begin
						state_q    <= phy_mgmt_pkg::ENG_RUN;
						op_q       <= start_wr ? phy_mgmt_pkg::OP_WRITE : phy_mgmt_pkg::OP_READ;
						cnt_q      <= CNT_W'(MGMT_CYCLES - 1);
						acc_addr_q <= phy_reg_select_q;
					end
				end
				phy_mgmt_pkg::ENG_RUN: begin
					// serial access time
					if (cnt_q == '0)
						state_q <= phy_mgmt_pkg::ENG_FIN;
					else
						cnt_q <= cnt_q - 1'b1;
				end
				phy_mgmt_pkg::ENG_FIN: begin
					// scan restarts from idle on the next cycle
					state_q <= phy_mgmt_pkg::ENG_IDLE;
				end
				default: begin
					state_q <= phy_mgmt_pkg::ENG_IDLE;
				end
			endcase
		end
	end

	// command bits; the read bit clears itself when its read launches
	// limitation: a single read asked for while the scan runs is served by the
	// scan, and the bit stays set until software writes the command again
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			single_read_request_q    <= 1'b0;
			continuous_poll_enable_q <= 1'b0;
		end else if (wr_fire && idx == `IDX_MGMT_CMD) begin
			// a fresh write wins over the self-clear
			single_read_request_q    <= pwdata[`CMD_READ_BIT];
			continuous_poll_enable_q <= pwdata[`CMD_SCAN_BIT];
		end else if (start_rd && !continuous_poll_enable_q) begin
			// cleared at launch so exactly one read is made
			single_read_request_q <= 1'b0;
		end
	end

	// a single read and the scan share launches; the scan re-arms after each result
	always_ff @(posedge sys_clk) begin
		if (rst)
			phy_reg_select_q <= '0;
		else if (wr_fire && idx == `IDX_PHY_SEL)
			phy_reg_select_q <= pwdata[4:0];
	end

	// write data register; writing it queues a transceiver write
	// hazard: a second data write while one is queued would change the word the
	// engine is about to send, so it is dropped rather than merged
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			phy_write_data_q <= '0;
			write_req_q      <= 1'b0;
		end else if (wr_fire && idx == `IDX_PHY_WDATA && !write_req_q && !bank_wr) begin
			// ignored while a write is still waiting, so its data cannot change
			phy_write_data_q <= pwdata[15:0];
			write_req_q      <= 1'b1;
		end else if (wr_done) begin
			write_req_q <= 1'b0;
		end
	end

	// read result and its not-valid flag
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			phy_read_result_q     <= '0;
			read_result_pending_q <= 1'b0;
		end else if (start_rd) begin
			read_result_pending_q <= 1'b1;
		end else if (rd_done) begin
			phy_read_result_q     <= bank_rdata;
			read_result_pending_q <= 1'b0;
		end
	end

	// sticky events, set beats a same-cycle write-one clear
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_stat_q <= '0;
			irq_mask_q <= '0;
		end else begin
			if (wr_fire && idx == `IDX_IRQ_STAT)
				irq_stat_q <= (irq_stat_q & ~pwdata[`IRQ_WIDTH-1:0]) | {wr_done, rd_done};
			else
				irq_stat_q <= irq_stat_q | {wr_done, rd_done};
			if (wr_fire && idx == `IDX_IRQ_MASK)
				irq_mask_q <= pwdata[`IRQ_WIDTH-1:0];
		end
	end

	// interrupt line is registered, so it follows status and mask one cycle late
	always_ff @(posedge sys_clk) begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= |(irq_stat_q & irq_mask_q);
	end

	// status word; reserved and upper bits stay zero
	always_comb begin
		mgmt_status_reg                  = '0;
		mgmt_status_reg[`STAT_BUSY_BIT]  = (state_q != phy_mgmt_pkg::ENG_IDLE);
		mgmt_status_reg[`STAT_SCAN_BIT]  = continuous_poll_enable_q;
		mgmt_status_reg[`STAT_PEND_BIT]  = read_result_pending_q;
		mgmt_command_reg                 = '0;
		mgmt_command_reg[`CMD_READ_BIT]  = single_read_request_q;
		mgmt_command_reg[`CMD_SCAN_BIT]  = continuous_poll_enable_q;
	end

	// read mux, narrow registers sit in the low bits
	// words outside the map never reach prdata, the capture below gates on hit
	always_comb begin
		rd_mux = '0;
		case (idx)
			`IDX_MGMT_CMD:  rd_mux = {30'h0, mgmt_command_reg};
			`IDX_MGMT_STAT: rd_mux = {29'h0, mgmt_status_reg};
			`IDX_PHY_SEL:   rd_mux = {27'h0, phy_reg_select_q};
			`IDX_PHY_WDATA: rd_mux = {16'h0, phy_write_data_q};
			`IDX_PHY_RDATA: rd_mux = {16'h0, phy_read_result_q};
			`IDX_SIL_REV:   rd_mux = {27'h0, SILICON_REV};
			`IDX_IRQ_STAT:  rd_mux = {30'h0, irq_stat_q};
			`IDX_IRQ_MASK:  rd_mux = {30'h0, irq_mask_q};
			default:        rd_mux = '0;
		endcase
	end

	// read data captured in the first access cycle
	always_ff @(posedge sys_clk) begin
		if (rst)
			prdata <= '0;
		else if (rd_fire)
			prdata <= (hit && !pwrite) ? rd_mux : 32'h0000_0000;
	end

endmodule

// ### hw/phy_mgmt_regs.svh
`ifndef PHY_MGMT_REGS_SVH
`define PHY_MGMT_REGS_SVH

// apb word indices, byte address is four times the index
`define IDX_MGMT_CMD      4'h0
`define IDX_MGMT_STAT     4'h1
`define IDX_PHY_SEL       4'h2
`define IDX_PHY_WDATA     4'h3
`define IDX_PHY_RDATA     4'h4
`define IDX_SIL_REV       4'h5
`define IDX_IRQ_STAT      4'h6
`define IDX_IRQ_MASK      4'h7
`define IDX_LAST          4'h7

// management command bits
`define CMD_READ_BIT      0
`define CMD_SCAN_BIT      1
`define CMD_WIDTH         2

// management status bits, bit 3 is reserved and reads zero
`define STAT_BUSY_BIT     0
`define STAT_SCAN_BIT     1
`define STAT_PEND_BIT     2
`define STAT_WIDTH        3

// interrupt status bits
`define IRQ_READ_BIT      0
`define IRQ_WRITE_BIT     1
`define IRQ_WIDTH         2

// transceiver register addresses
`define PHY_ADDR_STAT_LATCH 5'h01
`define PHY_ADDR_IDENT_HI   5'h02
`define PHY_ADDR_IDENT_LO   5'h03
`define PHY_ADDR_STAT_LIVE  5'h11
`define PHY_ADDR_IRQ_FLAGS  5'h13
`define PHY_ADDR_LED_CFG    5'h14

// latched status layout
`define PS1_FULL_CAP_BIT  12
`define PS1_HALF_CAP_BIT  11
`define PS1_LINK_BIT      2
`define PS1_JABBER_BIT    1

// live status layout
`define PS2_TX_BIT        13
`define PS2_RX_BIT        12
`define PS2_COL_BIT       11
`define PS2_LINK_BIT      10
`define PS2_DPX_BIT       9
`define PS2_POL_BIT       5

// reset value and default cycles per access
`define LED_CFG_RESET     16'h3422
`define MGMT_CYCLES       16

`endif

// ### hw/phy_mgmt_pkg.sv
package phy_mgmt_pkg;

	// management engine states, one-hot
	typedef enum logic [2:0] {
		ENG_IDLE = 3'b001,
		ENG_RUN  = 3'b010,
		ENG_FIN  = 3'b100
	} eng_state_t;

	// kind of transceiver access in flight
	typedef enum logic [1:0] {
		OP_READ  = 2'b01,
		OP_WRITE = 2'b10
	} eng_op_t;

endpackage

// ### hw/pin_sync.sv
// two flops per bit before any logic sees a pin level
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;  // first stage, read only by second

	// plain two-stage chain
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

// ### hw/phy_reg_bank.sv
`include "phy_mgmt_regs.svh"

// transceiver-side register file on the internal management link
module phy_reg_bank #(
	parameter logic [21:0] VENDOR_BITS = 22'h000155, // arbitrary value
	parameter logic [5:0]  PART_FIELD  = 6'h11,      // arbitrary value
	parameter logic [3:0]  REV_FIELD   = 4'h2        // arbitrary value
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        rd_en,
	input  wire logic        wr_en,
	input  wire logic [4:0]  addr,
	input  wire logic [15:0] wdata,
	output logic      [15:0] rdata,
	output logic      [15:0] led_config,
	input  wire logic        link_up,
	input  wire logic        jabber,
	input  wire logic        tx_act,
	input  wire logic        rx_act,
	input  wire logic        col_act,
	input  wire logic        full_dpx,
	input  wire logic        pol_rev
);

	logic        link_held_low_flag; // zero once link dropped since last read
	logic        jabber_flag;        // one once jabber seen since last read
	logic        rd_latched;         // read of the latched status register
	logic [15:0] phy_status_latched;
	logic [15:0] phy_status_live;
	logic [15:0] phy_ident_high;
	logic [15:0] phy_ident_low;

	assign rd_latched = rd_en && (addr == `PHY_ADDR_STAT_LATCH);

	// latched link and jabber; a read re-arms from the live level so an event in that cycle survives
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			link_held_low_flag <= 1'b0;
			jabber_flag        <= 1'b0;
		end else if (rd_latched) begin
			link_held_low_flag <= link_up;
			jabber_flag        <= jabber;
		end else begin
			link_held_low_flag <= link_held_low_flag & link_up;
			jabber_flag        <= jabber_flag | jabber;
		end
	end

	always_comb begin
		phy_status_latched                    = '0;
		phy_status_latched[`PS1_FULL_CAP_BIT] = 1'b1;
		phy_status_latched[`PS1_HALF_CAP_BIT] = 1'b1;
		phy_status_latched[`PS1_LINK_BIT]     = link_held_low_flag;
		phy_status_latched[`PS1_JABBER_BIT]   = jabber_flag;
		phy_status_live                       = '0;
		phy_status_live[`PS2_TX_BIT]          = tx_act;
		phy_status_live[`PS2_RX_BIT]          = rx_act;
		phy_status_live[`PS2_COL_BIT]         = col_act;
		phy_status_live[`PS2_LINK_BIT]        = link_up;
		phy_status_live[`PS2_DPX_BIT]         = full_dpx;
		phy_status_live[`PS2_POL_BIT]         = pol_rev;
	end

	// fixed identity words
	assign phy_ident_high = VENDOR_BITS[21:6];
	assign phy_ident_low  = {VENDOR_BITS[5:0], PART_FIELD, REV_FIELD};

	// registered read data; only the led word is writable
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rdata      <= '0;
			led_config <= `LED_CFG_RESET;
		end else begin
			if (wr_en && addr == `PHY_ADDR_LED_CFG)
				led_config <= wdata;
			if (rd_en) begin
				case (addr)
					`PHY_ADDR_STAT_LATCH: rdata <= phy_status_latched;
					`PHY_ADDR_STAT_LIVE:  rdata <= phy_status_live;
					`PHY_ADDR_IDENT_HI:   rdata <= phy_ident_high;
					`PHY_ADDR_IDENT_LO:   rdata <= phy_ident_low;
					`PHY_ADDR_LED_CFG:    rdata <= led_config;
					default:              rdata <= '0; // irq flags and holes read zero
				endcase
			end
		end
	end

endmodule

// ### tb/phy_mgmt_status_regs_checker.sv
// watches the register bus and the interrupt line of the status block
module phy_mgmt_status_regs_checker #(
	parameter logic [4:0] SILICON_REV = 5'h06 // must match the instance
) (
	input wire logic        sys_clk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	// completed read and its word index
	wire logic       rd_ok = psel && penable && pready && !pwrite;
	wire logic [3:0] idx   = paddr[5:2];

	a_ready_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
		else $error("pready not on second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	a_unmapped_err: assert property (psel && penable && pready && (paddr[5] || paddr[1:0] != 2'h0) |-> pslverr)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (psel && penable && pready && paddr[31:5] == 27'h0 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("mapped access refused");
	a_cmd_upper: assert property (rd_ok && idx == 4'h0 |-> prdata[31:2] == 30'h0)
		else $error("command upper bits not zero");
	a_stat_upper: assert property (rd_ok && idx == 4'h1 |-> prdata[31:3] == 29'h0)
		else $error("status upper bits not zero");
	a_silicon_rev: assert property (rd_ok && idx == 4'h5 |-> prdata == {27'h0, SILICON_REV})
		else $error("silicon revision code wrong");
	a_result_width: assert property (rd_ok && idx == 4'h4 |-> prdata[31:16] == 16'h0)
		else $error("read result wider than a word");
	a_pend_busy: assert property (rd_ok && idx == 4'h1 && prdata[2] |-> prdata[0])
		else $error("pending shown with engine idle");
	a_irq_quiet: assert property ($fell(rst) |-> !irq)
		else $error("interrupt high out of reset");

	// main scenarios reached
	c_scan_seen: cover property (rd_ok && idx == 4'h1 && prdata[1]);
	c_irq_seen: cover property ($rose(irq));
	c_refused: cover property (pready && pslverr);
endmodule

// ### tb/phy_line_model.sv
// far end of the transceiver: line status levels seen at the pins
module phy_line_model (
	input  wire logic sys_clk,
	output logic      link_up_pin,
	output logic      jabber_pin,
	output logic      tx_active_pin,
	output logic      rx_active_pin,
	output logic      collision_pin,
	output logic      full_duplex_pin,
	output logic      polarity_rev_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	// quiet line until told otherwise
	initial begin
		{tx_active_pin, rx_active_pin, collision_pin, link_up_pin, full_duplex_pin, polarity_rev_pin} = 6'h00;
		jabber_pin = 1'b0;
	end

	// live levels, order tx rx col link duplex polarity
	task automatic set_live(input logic [5:0] v);
		@(posedge sys_clk);
		{tx_active_pin, rx_active_pin, collision_pin, link_up_pin, full_duplex_pin, polarity_rev_pin} <= v;
	endtask

	// short outage, longer than the pin synchroniser
	task automatic link_blip(input int n);
		@(posedge sys_clk);
		link_up_pin <= 1'b0;
		repeat (n) @(posedge sys_clk);
		link_up_pin <= 1'b1;
	endtask

	// brief run-on transmission burst
	task automatic jabber_blip(input int n);
		@(posedge sys_clk);
		jabber_pin <= 1'b1;
		repeat (n) @(posedge sys_clk);
		jabber_pin <= 1'b0;
	endtask
endmodule

// ### tb/phy_mgmt_status_regs_test.sv
`include "phy_mgmt_regs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("BAD %0t got %h want %h", $time, g, e); end end

module phy_mgmt_status_regs_test;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [4:0]  SIL    = 5'h06;     // arbitrary value
	localparam logic [21:0] VENDOR = 22'h000155; // arbitrary value
	localparam logic [5:0]  PART   = 6'h11;     // arbitrary value
	localparam logic [3:0]  REV    = 4'h2;      // arbitrary value

	logic        sys_clk = 1'b0;
	logic        rst     = 1'b1;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [31:0] paddr   = 32'h0;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic [15:0] led_config;
	wire logic   lnk, jab, txa, rxa, col, dpx, pol; // line pins from the far end
	logic [31:0] rv;                               // last read word
	logic        er;                               // last error flag
	int          n_errors    = 0;
	int          comparisons = 0;

	// 250 MHz
	always #2 sys_clk = ~sys_clk;

	// short access count keeps the run brief
	// identity fields stay at the design defaults, mirrored by the local copies above
	phy_mgmt_status_regs #(.MGMT_CYCLES(4), .SILICON_REV(SIL)) dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.led_config(led_config), .link_up_pin(lnk), .jabber_pin(jab), .tx_active_pin(txa),
		.rx_active_pin(rxa), .collision_pin(col), .full_duplex_pin(dpx), .polarity_rev_pin(pol));

	phy_line_model line (.sys_clk(sys_clk), .link_up_pin(lnk), .jabber_pin(jab), .tx_active_pin(txa),
		.rx_active_pin(rxa), .collision_pin(col), .full_duplex_pin(dpx), .polarity_rev_pin(pol));

	// one bus transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [3:0] idx, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {26'h0, idx, 2'h0};
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_errors++;
			$display("BAD %0t no pready", $time);
		end
		rv = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [3:0] idx, input logic [31:0] e);
		apb(1'b0, idx, 32'h0);
		`CHK(rv, e)
	endtask

	// poll status until the engine has nothing in hand
	task automatic wait_idle();
		int k;
		k = 0;
		do begin
			apb(1'b0, `IDX_MGMT_STAT, 32'h0);
			k++;
		end while (rv[2:0] !== 3'h0 && k < 30);
		if (k >= 30) begin
			n_errors++;
			$display("BAD %0t engine stuck", $time);
		end
	endtask

	// single read of one transceiver register, result left in rv
	task automatic phy_rd(input logic [4:0] a);
		apb(1'b1, `IDX_PHY_SEL, {27'h0, a});
		apb(1'b1, `IDX_MGMT_CMD, 32'h1);
		wait_idle();
		apb(1'b0, `IDX_PHY_RDATA, 32'h0);
	endtask

	task automatic give_verdict();
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// watchdog, runs well past the expected few hundred cycles
	initial begin
		#40000;
		n_errors++;
		$display("BAD %0t watchdog", $time);
		give_verdict();
	end

	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		// reset state, read-only revision, unmapped word
		rd_chk(`IDX_MGMT_CMD, 32'h0);
		rd_chk(`IDX_MGMT_STAT, 32'h0);
		apb(1'b1, `IDX_SIL_REV, 32'h1F);
		rd_chk(`IDX_SIL_REV, {27'h0, SIL});
		apb(1'b0, 4'h8, 32'h0);
		`CHK(er, 1'b1)
		`CHK(led_config, 16'h3422)
		$display("test reset done");
		// identity words and the single-read handshake
		apb(1'b1, `IDX_PHY_SEL, {27'h0, `PHY_ADDR_IDENT_HI});
		apb(1'b1, `IDX_MGMT_CMD, 32'h1);
		rd_chk(`IDX_MGMT_STAT, 32'h5);
		rd_chk(`IDX_MGMT_CMD, 32'h0);
		wait_idle();
		rd_chk(`IDX_PHY_RDATA, {16'h0, VENDOR[21:6]});
		phy_rd(`PHY_ADDR_IDENT_LO);
		`CHK(rv, {16'h0, VENDOR[5:0], PART, REV})
		// interrupt: raised, masked, unmasked, cleared
		rd_chk(`IDX_IRQ_STAT, 32'h1);
		`CHK(irq, 1'b0)
		apb(1'b1, `IDX_IRQ_MASK, 32'h1);
		repeat (2) @(posedge sys_clk);
		`CHK(irq, 1'b1)
		apb(1'b1, `IDX_IRQ_STAT, 32'h1);
		repeat (2) @(posedge sys_clk);
		`CHK(irq, 1'b0)
		// a write to an identity word must not stick; write-done stays masked
		apb(1'b1, `IDX_PHY_WDATA, 32'hFFFF);
		wait_idle();
		`CHK(irq, 1'b0)
		phy_rd(`PHY_ADDR_IDENT_LO);
		`CHK(rv, {16'h0, VENDOR[5:0], PART, REV})
		$display("test ident done");
		// live line status
		line.set_live(6'b110101);
		phy_rd(`PHY_ADDR_STAT_LIVE);
		`CHK(rv, 32'h3420)
		line.set_live(6'b001010);
		phy_rd(`PHY_ADDR_STAT_LIVE);
		`CHK(rv, 32'h0A00)
		line.set_live(6'b000100);
		$display("test live done");
		// latched link and jabber flags, re-armed by each read
		phy_rd(`PHY_ADDR_STAT_LATCH);
		phy_rd(`PHY_ADDR_STAT_LATCH);
		`CHK(rv, 32'h1804)
		line.link_blip(6);
		repeat (4) @(posedge sys_clk);
		phy_rd(`PHY_ADDR_STAT_LATCH);
		`CHK(rv, 32'h1800)
		phy_rd(`PHY_ADDR_STAT_LATCH);
		`CHK(rv, 32'h1804)
		line.jabber_blip(6);
		repeat (4) @(posedge sys_clk);
		phy_rd(`PHY_ADDR_STAT_LATCH);
		`CHK(rv, 32'h1806)
		phy_rd(`PHY_ADDR_STAT_LATCH);
		`CHK(rv, 32'h1804)
		$display("test latch done");
		// continuous poll follows the live word
		apb(1'b1, `IDX_PHY_SEL, {27'h0, `PHY_ADDR_STAT_LIVE});
		apb(1'b1, `IDX_MGMT_CMD, 32'h2);
		rd_chk(`IDX_MGMT_STAT, 32'h7);
		line.set_live(6'b100100);
		repeat (40) @(posedge sys_clk);
		rd_chk(`IDX_PHY_RDATA, 32'h2400);
		line.set_live(6'b010100);
		repeat (40) @(posedge sys_clk);
		rd_chk(`IDX_PHY_RDATA, 32'h1400);
		apb(1'b1, `IDX_MGMT_CMD, 32'h0);
		wait_idle();
		rd_chk(`IDX_MGMT_STAT, 32'h0);
		$display("test scan done");
		// transceiver write lands in the led word and raises write-done
		apb(1'b1, `IDX_IRQ_STAT, 32'h3);
		apb(1'b1, `IDX_PHY_SEL, {27'h0, `PHY_ADDR_LED_CFG});
		apb(1'b1, `IDX_PHY_WDATA, 32'h1234);
		wait_idle();
		`CHK(led_config, 16'h1234)
		rd_chk(`IDX_IRQ_STAT, 32'h2);
		phy_rd(`PHY_ADDR_LED_CFG);
		`CHK(rv, 32'h1234)
		$display("test write done");
		give_verdict();
	end
endmodule

bind phy_mgmt_status_regs phy_mgmt_status_regs_checker #(.SILICON_REV(SILICON_REV)) chk (.sys_clk(sys_clk),
	.rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq(irq));
